/* bench/led_ctl_model.sv */
// controller model driving the serial link pins of the sink driver
`timescale 1ns/1ps
module led_ctl_model (
  // clock
  input  wire logic mclk,
  // link pins
  output logic      sclk,
  output logic      serial_in,
  output logic      latch_strobe_detect_ctl1,
  output logic      output_blank_n_detect_ctl2
);
  // ----
  // pin drive
  // ----
  initial begin
    sclk = 1'b0;
    serial_in = 1'b0;
    latch_strobe_detect_ctl1 = 1'b0;
    output_blank_n_detect_ctl2 = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // three mclk per phase: slower than the pin sync needs, and under the rated rate
  task automatic step(input logic d, input logic strobe, input logic blank_n);
    serial_in = d;
    latch_strobe_detect_ctl1 = strobe;
    output_blank_n_detect_ctl2 = blank_n;
    wait_clk(3);
    sclk = 1'b1;
    wait_clk(3);
    sclk = 1'b0;
    wait_clk(3);
  endtask

  // sclk stays still here, so the mode history is left alone
  task automatic pins(input logic strobe, input logic blank_n, input int n);
    latch_strobe_detect_ctl1 = strobe;
    output_blank_n_detect_ctl2 = blank_n;
    wait_clk(n);
  endtask
endmodule // led_ctl_model

/* bench/led_sink_shift_latch_detect_tb.sv */
// self-checking bench for the led sink shift/latch/detect block
`timescale 1ns/1ps
module led_sink_shift_latch_detect_tb;
  import led_sink_pkg::*;
  logic                mclk      = 1'b0;
  logic                rst       = 1'b1;
  logic [CHANNELS-1:0] led_fault = 16'h0000;
  logic                sclk;
  logic                serial_in;
  logic                latch_strobe_detect_ctl1;
  logic                output_blank_n_detect_ctl2;
  logic                serial_out;
  logic [CHANNELS-1:0] sink_outputs;
  logic                detect_mode;
  int                  error_cnt = 0;
  int                  checks    = 0;

  always #20 mclk = ~mclk;

  led_sink_shift_latch_detect u_led_sink_shift_latch_detect (
    .mclk, .rst, .sclk, .serial_in, .latch_strobe_detect_ctl1,
    .output_blank_n_detect_ctl2, .led_fault, .serial_out, .sink_outputs, .detect_mode
  );
  led_ctl_model u_led_ctl_model (
    .mclk, .sclk, .serial_in, .latch_strobe_detect_ctl1, .output_blank_n_detect_ctl2
  );

  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // first bit sent lands in channel 15; old word leaves on serial_out
  task automatic shift_word(input logic [15:0] w, input logic [15:0] old, input logic blank_n);
    for (int i = 15; i >= 0; i--) begin
      chk(16'(serial_out), 16'(old[i]), "serial_out");
      u_led_ctl_model.step(w[i], 1'b0, blank_n);
    end
  endtask

  task automatic strobe_pulse;
    u_led_ctl_model.pins(1'b1, 1'b0, 4);
    u_led_ctl_model.pins(1'b0, 1'b0, 4);
  endtask

  task automatic send_pat(input logic [HIST_W-1:0] pat);
    logic [1:0] p;
    for (int i = 0; i < SEQ_LEN; i++) begin
      p = pat[HIST_W-1-2*i -: 2];
      u_led_ctl_model.step(1'b1, p[1], p[0]);
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk(sink_outputs, 16'h0000, "reset sinks");
    chk(16'(detect_mode), 16'h0000, "reset mode");
    chk(16'(serial_out), 16'h0000, "reset sout");
  endtask

  task automatic t_load;
    shift_word(16'ha5c3, 16'h0000, 1'b0);
    strobe_pulse();
    chk(sink_outputs, 16'ha5c3, "load");
    u_led_ctl_model.pins(1'b0, 1'b1, 6);
    chk(sink_outputs, 16'h0000, "blank");
    u_led_ctl_model.pins(1'b0, 1'b0, 6);
    chk(sink_outputs, 16'ha5c3, "unblank");
  endtask

  task automatic t_freeze;
    shift_word(16'h0ff0, 16'ha5c3, 1'b0);
    chk(sink_outputs, 16'ha5c3, "frozen");
    strobe_pulse();
    chk(sink_outputs, 16'h0ff0, "relatch");
  endtask

  task automatic t_detect;
    send_pat(ENTRY_PAT_RST);
    chk(16'(detect_mode), 16'h0001, "entry");
    u_led_ctl_model.pins(1'b0, 1'b0, 6);
    chk(sink_outputs, 16'h0ff0, "no latch");
    u_led_ctl_model.pins(1'b0, 1'b1, 4);
    led_fault = 16'h8421;
    u_led_ctl_model.pins(1'b0, 1'b0, 60);
    u_led_ctl_model.pins(1'b0, 1'b1, 8);
    // default polarity: a low status bit marks a faulty channel
    shift_word(16'h0000, 16'h7bde, 1'b1);
    chk(16'(detect_mode), 16'h0001, "still detect");
  endtask

  task automatic t_exit;
    send_pat(EXIT_PAT_RST);
    chk(16'(detect_mode), 16'h0000, "exit");
    strobe_pulse();
    // the switch steps shifted five ones in behind the sixteen zeros read out
    chk(sink_outputs, 16'h001f, "normal latch");
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    u_led_ctl_model.wait_clk(2);
    t_reset();
    t_load();
    t_freeze();
    t_detect();
    t_exit();
    end_sim();
  end
endmodule // led_sink_shift_latch_detect_tb

/* src/led_sink_pkg.sv */
// shared constants and types for the led sink shift/latch/detect block
package led_sink_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS = 16;
  localparam int SEQ_LEN  = 5;
  localparam int HIST_W   = 2 * SEQ_LEN;
  localparam int PRE_W    = 6;
  localparam int LOW_W    = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int DETECT_LOW_NS  = 2000;
  localparam int DETECT_LOW_CYC = (DETECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [LOW_W-1:0] LOW_CYC  = LOW_W'(DETECT_LOW_CYC);
  localparam logic [LOW_W-1:0] LOW_SAT  = 6'h3f;

  // ----------------------------------------------------------------
  // mode switch patterns, {strobe, blank_n} per serial clock, oldest first
  // ----------------------------------------------------------------
  localparam logic [HIST_W-1:0] ENTRY_PAT_RST = 10'h11d;
  localparam logic [HIST_W-1:0] EXIT_PAT_RST  = 10'h115;
  localparam logic              ERR_LEVEL_RST = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_DETECT = 1'b1
  } mode_t;

  typedef struct packed {
    logic sclk;
    logic sin;
    logic strobe;
    logic blank_n;
  } pins_t;

  typedef struct packed {
    pins_t                 pin_s1;
    pins_t                 pin_s2;
    logic                  clk_d;
    logic                  blank_d;
    logic [CHANNELS-1:0]   led_s1;
    logic [CHANNELS-1:0]   led_s2;
    logic [CHANNELS-1:0]   shift;
    logic [CHANNELS-1:0]   latch;
    logic [CHANNELS-1:0]   sink;
    logic [HIST_W-1:0]     hist;
    logic [LOW_W-1:0]      low_cnt;
    mode_t                 mode;
    logic                  sout;
  } state_t;

  localparam pins_t PINS_RST = '{sclk: 1'b0, sin: 1'b0, strobe: 1'b0, blank_n: 1'b1};

  localparam state_t STATE_RST = '{
    pin_s1: PINS_RST, pin_s2: PINS_RST, clk_d: 1'b0, blank_d: 1'b1,
    led_s1: 16'h0000, led_s2: 16'h0000, shift: 16'h0000,
    latch: 16'h0000, sink: 16'h0000, hist: 10'h000,
    low_cnt: 6'h00, mode: MODE_NORMAL, sout: 1'b0
  };

endpackage

/* src/led_sink_shift_latch_detect.sv */
// serial shift register, strobe latch, blanking and open/short detect mode
`timescale 1ns/1ps
// Notes on behaviour
// - each rising serial clock edge shifts serial_in into the register, except one coinciding with a status capture
// - sixteen-bit shift register feeds sixteen latches, serial to parallel
// - strobe high passes shift register contents straight into the latches
// - strobe low freezes the latches while shifting carries on
// - blank_n low drives every sink from its latched bit
// - blank_n high turns every sink off whatever the latch holds
// - last shift stage appears on serial_out for cascading
// - sixteen independent sink outputs, one latched bit each
// - a fixed strobe/blank/clock sequence enters detection mode
// - strobe pulses never update latches in or entering detection mode
// - detection mode loads per-channel LED status into the shift register
// - status is read out on serial_out, one bit per clock
// - a second fixed sequence returns to normal mode
module led_sink_shift_latch_detect
  import led_sink_pkg::*;
#(
  parameter logic [HIST_W-1:0] ENTRY_PAT = ENTRY_PAT_RST,
  parameter logic [HIST_W-1:0] EXIT_PAT  = EXIT_PAT_RST,
  parameter logic              ERR_LEVEL = ERR_LEVEL_RST
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // serial link pins from the controller
  input  wire logic                sclk,
  input  wire logic                serial_in,
  input  wire logic                latch_strobe_detect_ctl1,
  input  wire logic                output_blank_n_detect_ctl2,
  // per-channel fault sense from the output stage, high on a fault
  input  wire logic [CHANNELS-1:0] led_fault,
  // outputs
  output logic                     serial_out,
  output logic [CHANNELS-1:0]      sink_outputs,
  output logic                     detect_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t               r;
  state_t               next_r;
  pins_t                pins;
  logic                 rise_ev;
  logic                 blank_rise;
  logic                 cap_ev;
  logic                 armed;
  logic                 entry_hit;
  logic                 exit_hit;
  logic [HIST_W-1:0]    hist_new;
  logic [CHANNELS-1:0]  status;

  assign pins = '{
    sclk:    sclk,
    sin:     serial_in,
    strobe:  latch_strobe_detect_ctl1,
    blank_n: output_blank_n_detect_ctl2
  };

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  // edges seen on the second sync stage only; sclk must stay well under mclk/2
  assign rise_ev    = r.pin_s2.sclk & ~r.clk_d;
  assign blank_rise = r.pin_s2.blank_n & ~r.blank_d;
  assign hist_new   = {r.hist[HIST_W-3:0], r.pin_s2.strobe, r.pin_s2.blank_n};
  assign entry_hit  = (r.mode == MODE_NORMAL) && (hist_new == ENTRY_PAT);
  assign exit_hit   = (r.mode == MODE_DETECT) && (hist_new == EXIT_PAT);
  // the first three steps of the entry sequence already hold the latches; the fourth
  // step carries strobe high, so its prefix must hold them until the last step lands
  assign armed      = (r.hist[PRE_W-1:0] == ENTRY_PAT[HIST_W-1:HIST_W-PRE_W]) ||
                      (r.hist[HIST_W-3:0] == ENTRY_PAT[HIST_W-1:2]);
  // sensing needs the sinks lit for a full minimum low time first
  assign cap_ev     = blank_rise && (r.mode == MODE_DETECT) && (r.low_cnt >= LOW_CYC);
  assign status     = ERR_LEVEL ? r.led_s2 : ~r.led_s2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.pin_s1 = pins;
    next_r.pin_s2 = r.pin_s1;
    next_r.led_s1 = led_fault;
    next_r.led_s2 = r.led_s1;
    next_r.clk_d  = r.pin_s2.sclk;
    next_r.blank_d = r.pin_s2.blank_n;

    if (r.pin_s2.blank_n) begin
      next_r.low_cnt = '0;
    end else if (r.low_cnt != LOW_SAT) begin
      next_r.low_cnt = r.low_cnt + 6'h01;
    end

    // capture wins over a coincident shift so status is never half lost
    if (cap_ev) begin
      next_r.shift = status;
    end else if (rise_ev) begin
      next_r.shift = {r.shift[CHANNELS-2:0], r.pin_s2.sin};
    end

    if (rise_ev) begin
      next_r.hist = hist_new;
      if (entry_hit) begin
        next_r.mode = MODE_DETECT;
      end else if (exit_hit) begin
        next_r.mode = MODE_NORMAL;
      end
    end

    // transparent while high, frozen while low, in detect mode or while armed
    if (r.pin_s2.strobe && (r.mode == MODE_NORMAL) && !armed) begin
      next_r.latch = r.shift;
    end

    next_r.sink = r.pin_s2.blank_n ? '0 : r.latch;
    next_r.sout = r.shift[CHANNELS-1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= STATE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign serial_out   = r.sout;
  assign sink_outputs = r.sink;
  assign detect_mode  = r.mode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_shift_edge;
    rise_ev && !cap_ev;
  endsequence

  sequence s_entry_step;
    rise_ev && entry_hit;
  endsequence

  sequence s_exit_step;
    rise_ev && exit_hit;
  endsequence

  sequence s_blank_release;
    blank_rise && (r.mode == MODE_DETECT);
  endsequence

  property p_shift;
    @(posedge mclk) disable iff (rst)
      s_shift_edge |=> r.shift == {$past(r.shift[CHANNELS-2:0]), $past(r.pin_s2.sin)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

  property p_no_edge_hold;
    @(posedge mclk) disable iff (rst)
      (!rise_ev && !cap_ev) |=> $stable(r.shift);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("shift moved without edge");

  property p_pin_to_shift;
    @(posedge mclk) disable iff (rst)
      (r.mode == MODE_NORMAL && !r.pin_s1.blank_n && !r.pin_s1.sclk) ##1
      (r.pin_s1.sclk && !r.pin_s1.blank_n) ##1 1'b1 |=> r.shift[0] == $past(r.pin_s2.sin);
  endproperty
  a_pin_to_shift: assert property (p_pin_to_shift) else $error("bit 0 not newest bit");

  property p_latch_open;
    @(posedge mclk) disable iff (rst)
      (r.pin_s2.strobe && r.mode == MODE_NORMAL && !armed) |=> r.latch == $past(r.shift);
  endproperty
  a_latch_open: assert property (p_latch_open) else $error("latch not transparent");

  property p_latch_hold;
    @(posedge mclk) disable iff (rst)
      !r.pin_s2.strobe |=> $stable(r.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed with strobe low");

  property p_detect_hold;
    @(posedge mclk) disable iff (rst)
      (r.mode == MODE_DETECT || armed) |=> $stable(r.latch);
  endproperty
  a_detect_hold: assert property (p_detect_hold) else $error("strobe latched in detect");

  property p_drive;
    @(posedge mclk) disable iff (rst)
      !r.pin_s2.blank_n |=> sink_outputs == $past(r.latch);
  endproperty
  a_drive: assert property (p_drive) else $error("sinks do not follow latch");

  property p_blank;
    @(posedge mclk) disable iff (rst)
      r.pin_s2.blank_n [*2] |=> sink_outputs == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("sinks not blanked");

  property p_cascade;
    @(posedge mclk) disable iff (rst)
      $changed(r.shift[CHANNELS-1]) |=> serial_out == $past(r.shift[CHANNELS-1]);
  endproperty
  a_cascade: assert property (p_cascade) else $error("serial_out not last stage");

  property p_enter;
    @(posedge mclk) disable iff (rst)
      s_entry_step |=> detect_mode ##1 $stable(r.latch);
  endproperty
  a_enter: assert property (p_enter) else $error("entry sequence missed");

  property p_capture;
    @(posedge mclk) disable iff (rst)
      s_blank_release ##0 (r.low_cnt >= LOW_CYC) |=> r.shift == $past(status);
  endproperty
  a_capture: assert property (p_capture) else $error("status not captured");

  property p_short_low;
    @(posedge mclk) disable iff (rst)
      s_blank_release ##0 (r.low_cnt < LOW_CYC) ##0 !rise_ev |=> $stable(r.shift);
  endproperty
  a_short_low: assert property (p_short_low) else $error("capture after short low");

  property p_exit;
    @(posedge mclk) disable iff (rst)
      s_exit_step |=> !detect_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit sequence missed");

  property p_mode_only_on_edge;
    @(posedge mclk) disable iff (rst)
      !rise_ev |=> $stable(detect_mode);
  endproperty
  a_mode_only_on_edge: assert property (p_mode_only_on_edge) else $error("mode moved");

  // ----------------------------------------------------------------
  // mode, count and drive checks
  // ----------------------------------------------------------------
  sequence s_entry_four;
    (r.mode == MODE_NORMAL) && (r.hist[HIST_W-3:0] == ENTRY_PAT[HIST_W-1:2]);
  endsequence

  property p_entry_four;
    @(posedge mclk) disable iff (rst)
      s_entry_four |=> $stable(r.latch);
  endproperty
  a_entry_four: assert property (p_entry_four) else $error("latched on entry");

  property p_stay_normal;
    @(posedge mclk) disable iff (rst)
      (rise_ev && !entry_hit && r.mode == MODE_NORMAL) |=> !detect_mode;
  endproperty
  a_stay_normal: assert property (p_stay_normal) else $error("left normal mode");

  property p_stay_detect;
    @(posedge mclk) disable iff (rst)
      (rise_ev && !exit_hit && r.mode == MODE_DETECT) |=> detect_mode;
  endproperty
  a_stay_detect: assert property (p_stay_detect) else $error("left detect mode");

  property p_no_cap_normal;
    @(posedge mclk) disable iff (rst)
      (blank_rise && r.mode == MODE_NORMAL && !rise_ev) |=> $stable(r.shift);
  endproperty
  a_no_cap_normal: assert property (p_no_cap_normal) else $error("capture in normal");

  property p_low_clear;
    @(posedge mclk) disable iff (rst)
      r.pin_s2.blank_n |=> r.low_cnt == '0;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low count not cleared");

  property p_low_count;
    @(posedge mclk) disable iff (rst)
      (!r.pin_s2.blank_n && r.low_cnt != LOW_SAT) |=> r.low_cnt == $past(r.low_cnt) + 6'h01;
  endproperty
  a_low_count: assert property (p_low_count) else $error("low count stuck");

  property p_sout_stage;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> serial_out == $past(r.shift[CHANNELS-1]);
  endproperty
  a_sout_stage: assert property (p_sout_stage) else $error("serial_out not bit 15");

  property p_sink_subset;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> (sink_outputs & ~$past(r.latch)) == '0;
  endproperty
  a_sink_subset: assert property (p_sink_subset) else $error("sink on without bit");

  property p_blank_now;
    @(posedge mclk) disable iff (rst)
      r.pin_s2.blank_n |=> sink_outputs == '0;
  endproperty
  a_blank_now: assert property (p_blank_now) else $error("sinks on while blanked");

  property p_hist_edge;
    @(posedge mclk) disable iff (rst)
      rise_ev |=> r.hist == $past(hist_new);
  endproperty
  a_hist_edge: assert property (p_hist_edge) else $error("history missed a step");

  property p_hist_hold;
    @(posedge mclk) disable iff (rst)
      !rise_ev |=> $stable(r.hist);
  endproperty
  a_hist_hold: assert property (p_hist_hold) else $error("history moved");

endmodule // led_sink_shift_latch_detect
